// ==== src/cks_top.sv ====
// Holds the register side: AXI4-Lite slave, start-up timer, status.
// Assumes oscillator ready pins are asynchronous to core_clk and
// cfg inputs come from logic on core_clk.
`timescale 1ns/1ps
`default_nettype none
module cks_top #(
	parameter int OST_CYCLES = cks_pkg::OST_CYCLES
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [cks_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [cks_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [2:0] primary_osc_config,
	input wire logic default_source_select_cfg,
	input wire logic cfg_loaded,
	input wire logic internal_osc_ready,
	input wire logic primary_osc_ready,
	input wire logic secondary_osc_ready,
	input wire logic sleep_exec,
	output logic [1:0] clk_source,
	output logic clk_hold,
	output logic [2:0] primary_mode,
	output logic sleep_enter,
	output logic idle_enter,
	output logic startup_timer_done,
	output logic secondary_clock_running
);

	// ==========================================================
	// Helpers
	function automatic logic [1:0] reg_hit(
		input logic [cks_pkg::ADDR_W-1:0] addr
	);
		logic [1:0] h;
		h = cks_pkg::HIT_NONE;
		if (addr == cks_pkg::OSC_CTRL_OFS) begin
			h = cks_pkg::HIT_OSC;
		end else if (addr == cks_pkg::TMR_CTRL_OFS) begin
			h = cks_pkg::HIT_TMR;
		end
		return h;
	endfunction : reg_hit

	// ==========================================================
	// State
	typedef struct packed {
		logic [2:0] sync1;
		logic [2:0] sync2;
		logic [cks_pkg::OST_CNT_W-1:0] ost_cnt;
		logic ost_done;
		logic cfg_done;
		logic dflt_pri;
		logic [2:0] pri_cfg;
		logic [1:0] sel;
		logic idle;
		logic sec_en;
		logic std;
		logic scr;
		logic sleep_p;
		logic idle_p;
		logic awready;
		logic wready;
		logic aw_have;
		logic w_have;
		logic [cks_pkg::ADDR_W-1:0] awaddr;
		logic [7:0] wdata;
		logic wstrb0;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [7:0] rdata;
	} cks_top_s;

	cks_top_s r;
	cks_top_s n;
	cks_pkg::cks_src_e sel_src;
	cks_pkg::cks_src_e req_src;
	logic [1:0] wr_hit;
	logic [1:0] rd_hit;

	cks_sw_if sw ();

	cks_switch u_switch (
		.core_clk(core_clk),
		.resetn(resetn),
		.sw(sw)
	);

	// ==========================================================
	// Source request
	always_comb begin
		sel_src = cks_pkg::SRC_INT;
		if (r.cfg_done) begin
			case (r.sel)
				cks_pkg::SEL_DFLT: begin
					sel_src = r.dflt_pri ? cks_pkg::SRC_PRI
						: cks_pkg::SRC_INT;
				end
				cks_pkg::SEL_SEC: begin
					sel_src = cks_pkg::SRC_SEC;
				end
				default: begin
					sel_src = cks_pkg::SRC_INT;
				end
			endcase
		end
		req_src = sel_src;
		if (sel_src == cks_pkg::SRC_SEC && !r.sec_en) begin
			req_src = sw.active_src;
		end
	end

	assign sw.req_src = req_src;
	assign sw.src_ready = {r.sync2[2] & r.sec_en, r.ost_done,
		r.sync2[0]};

	// ==========================================================
	// Next state
	always_comb begin
		n = r;
		wr_hit = reg_hit(r.awaddr);
		rd_hit = reg_hit(s_axi_araddr);
		n.sync1 = {secondary_osc_ready, primary_osc_ready,
			internal_osc_ready};
		n.sync2 = r.sync1;
		// Start-up timer runs while the primary reports ready.
		if (!r.sync2[1]) begin
			n.ost_cnt = '0;
			n.ost_done = 1'b0;
		end else if (r.ost_cnt !=
			cks_pkg::OST_CNT_W'(OST_CYCLES - 1)) begin
			n.ost_cnt = r.ost_cnt + 1'b1;
		end else begin
			n.ost_done = 1'b1;
		end
		if (cfg_loaded && !r.cfg_done) begin
			n.cfg_done = 1'b1;
			n.dflt_pri = default_source_select_cfg;
			n.pri_cfg = primary_osc_config;
		end
		if (!sw.hold) begin
			n.std = sw.active_src == cks_pkg::SRC_PRI && r.ost_done;
			n.scr = sw.active_src == cks_pkg::SRC_SEC;
		end
		n.sleep_p = sleep_exec && !r.idle;
		n.idle_p = sleep_exec && r.idle;
		// Write address and data may arrive in either order.
		if (s_axi_awvalid && r.awready) begin
			n.aw_have = 1'b1;
			n.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && r.wready) begin
			n.w_have = 1'b1;
			n.wdata = s_axi_wdata[7:0];
			n.wstrb0 = s_axi_wstrb[0];
		end
		if (r.bvalid && s_axi_bready) begin
			n.bvalid = 1'b0;
		end
		if (r.aw_have && r.w_have && !r.bvalid) begin
			n.aw_have = 1'b0;
			n.w_have = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = cks_pkg::RESP_OKAY;
			case (wr_hit)
				cks_pkg::HIT_OSC: begin
					if (r.wstrb0) begin
						n.sel = r.wdata[cks_pkg::SEL_MSB:
							cks_pkg::SEL_LSB];
						n.idle = r.wdata[cks_pkg::IDLE_BIT];
					end
				end
				cks_pkg::HIT_TMR: begin
					if (r.wstrb0) begin
						n.sec_en = r.wdata[cks_pkg::SECEN_BIT];
					end
				end
				default: begin
					n.bresp = cks_pkg::RESP_SLVERR;
				end
			endcase
		end
		n.awready = !n.aw_have && !n.bvalid;
		n.wready = !n.w_have && !n.bvalid;
		// Read channel.
		if (r.rvalid && s_axi_rready) begin
			n.rvalid = 1'b0;
		end
		if (s_axi_arvalid && r.arready) begin
			n.rvalid = 1'b1;
			n.rdata = 8'h00;
			n.rresp = cks_pkg::RESP_OKAY;
			case (rd_hit)
				cks_pkg::HIT_OSC: begin
					n.rdata[cks_pkg::SEL_MSB:cks_pkg::SEL_LSB] = r.sel;
					n.rdata[cks_pkg::STD_BIT] = r.std;
					n.rdata[cks_pkg::IDLE_BIT] = r.idle;
				end
				cks_pkg::HIT_TMR: begin
					n.rdata[cks_pkg::SECEN_BIT] = r.sec_en;
					n.rdata[cks_pkg::SCR_BIT] = r.scr;
				end
				default: begin
					n.rresp = cks_pkg::RESP_SLVERR;
				end
			endcase
		end
		n.arready = !n.rvalid;
	end

	// ==========================================================
	// Registers
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	// ==========================================================
	// Outputs
	assign s_axi_awready = r.awready;
	assign s_axi_wready = r.wready;
	assign s_axi_bresp = r.bresp;
	assign s_axi_bvalid = r.bvalid;
	assign s_axi_arready = r.arready;
	assign s_axi_rdata = {24'h000000, r.rdata};
	assign s_axi_rresp = r.rresp;
	assign s_axi_rvalid = r.rvalid;
	assign clk_source = sw.active_src;
	assign clk_hold = sw.hold;
	assign primary_mode = r.pri_cfg;
	assign sleep_enter = r.sleep_p;
	assign idle_enter = r.idle_p;
	assign startup_timer_done = r.std;
	assign secondary_clock_running = r.scr;

	// ==========================================================
	// Checks
	// status bits exclusive.
	property p_status_excl;
		@(posedge core_clk) disable iff (!resetn)
		!(r.std && r.scr);
	endproperty
	a_status_excl: assert property (p_status_excl)
		else $error("both source status bits set");

	property p_none_internal;
		@(posedge core_clk) disable iff (!resetn)
		(!r.std && !r.scr && !$past(sw.hold) && !$past(n.std)
			&& !$past(n.scr) && !sw.hold && !$past(r.std)
			&& $past(sw.active_src) == sw.active_src)
			|-> (sw.active_src == cks_pkg::SRC_INT
			|| (sw.active_src == cks_pkg::SRC_PRI && !$past(r.ost_done)));
	endproperty
	a_none_internal: assert property (p_none_internal)
		else $error("no status bit but non-internal source running");

	property p_idle_entry;
		@(posedge core_clk) disable iff (!resetn)
		(sleep_exec && r.idle) |=> (r.idle_p && !r.sleep_p);
	endproperty
	a_idle_entry: assert property (p_idle_entry)
		else $error("sleep with idle bit did not enter idle");

	property p_sleep_entry;
		@(posedge core_clk) disable iff (!resetn)
		(sleep_exec && !r.idle) |=> (r.sleep_p && !r.idle_p);
	endproperty
	a_sleep_entry: assert property (p_sleep_entry)
		else $error("sleep without idle bit did not enter sleep");

	property p_sec_refused;
		@(posedge core_clk) disable iff (!resetn)
		(sw.req_src == cks_pkg::SRC_SEC) |-> r.sec_en;
	endproperty
	a_sec_refused: assert property (p_sec_refused)
		else $error("secondary requested while its oscillator is off");

	property p_reset_sel;
		@(posedge core_clk) disable iff (!resetn)
		$rose(resetn) |-> (r.sel == cks_pkg::SEL_RST
			&& sw.active_src == cks_pkg::SRC_INT);
	endproperty
	a_reset_sel: assert property (p_reset_sel)
		else $error("select field not cleared after reset");

	property p_preload_int;
		@(posedge core_clk) disable iff (!resetn)
		!r.cfg_done |-> sw.active_src == cks_pkg::SRC_INT;
	endproperty
	a_preload_int: assert property (p_preload_int)
		else $error("non-internal clock before configuration load");

	property p_std_cause;
		@(posedge core_clk) disable iff (!resetn)
		$rose(r.std) |-> ($past(sw.active_src) == cks_pkg::SRC_PRI
			&& $past(r.ost_done) && !$past(sw.hold));
	endproperty
	a_std_cause: assert property (p_std_cause)
		else $error("timer done bit set without primary running");

	property p_status_hold;
		@(posedge core_clk) disable iff (!resetn)
		sw.hold |=> ($stable(r.std) && $stable(r.scr));
	endproperty
	a_status_hold: assert property (p_status_hold)
		else $error("status bit changed during clock transition");

endmodule : cks_top
`default_nettype wire

// ==== inc/cks_pkg.sv ====
// Constants, field positions and types for the clock source selector.
// Assumes a single 100 MHz core clock and an AXI4-Lite register master.
package cks_pkg;

	// ==========================================================
	// Clock sources
	typedef enum logic [1:0] {
		SRC_INT,
		SRC_PRI,
		SRC_SEC
	} cks_src_e;

	// ==========================================================
	// Register map
	localparam int ADDR_W = 4;
	localparam logic [3:0] OSC_CTRL_OFS = 4'h0;
	localparam logic [3:0] TMR_CTRL_OFS = 4'h4;
	localparam int SEL_LSB = 0;
	localparam int SEL_MSB = 1;
	localparam int STD_BIT = 3;
	localparam int IDLE_BIT = 7;
	localparam int SECEN_BIT = 3;
	localparam int SCR_BIT = 6;
	localparam logic [1:0] SEL_RST = 2'h0;
	localparam logic [1:0] SEL_DFLT = 2'h0;
	localparam logic [1:0] SEL_SEC = 2'h1;
	localparam logic [1:0] HIT_NONE = 2'h0;
	localparam logic [1:0] HIT_OSC = 2'h1;
	localparam logic [1:0] HIT_TMR = 2'h2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==========================================================
	// Cycle counts
	localparam int OST_CYCLES = 1024;
	localparam int OST_CNT_W = 11;
	localparam logic [1:0] OLD_PAUSE_CYC = 2'h2;
	localparam logic [1:0] NEW_PAUSE_CYC = 2'h3;

endpackage : cks_pkg

// ==== inc/cks_sw_if.sv ====
// Link between the register side and the clock switch sequencer.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
`default_nettype none
interface cks_sw_if;
	cks_pkg::cks_src_e req_src;
	cks_pkg::cks_src_e active_src;
	logic [2:0] src_ready;
	logic hold;
	modport ctl (output req_src, output src_ready,
		input active_src, input hold);
	modport seq (input req_src, input src_ready,
		output active_src, output hold);
endinterface : cks_sw_if
`default_nettype wire

// ==== src/cks_switch.sv ====
// Glitch-free clock switch sequencer.
// Assumes src_ready is synchronised and indexed by source.
`timescale 1ns/1ps
`default_nettype none
module cks_switch (
	input wire logic core_clk,
	input wire logic resetn,
	cks_sw_if.seq sw
);

	// ==========================================================
	// State
	typedef enum logic [1:0] {
		ST_RUN,
		ST_OLD,
		ST_WAIT,
		ST_NEW
	} cks_st_e;

	typedef struct packed {
		cks_st_e st;
		logic [1:0] cnt;
		cks_pkg::cks_src_e tgt;
		cks_pkg::cks_src_e active;
		logic hold;
	} cks_seq_s;

	cks_seq_s r;
	cks_seq_s n;

	assign sw.active_src = r.active;
	assign sw.hold = r.hold;

	// ==========================================================
	// Sequencer
	always_comb begin
		n = r;
		case (r.st)
			ST_RUN: begin
				if (sw.req_src != r.active) begin
					n.tgt = sw.req_src;
					n.hold = 1'b1;
					n.cnt = 2'h0;
					n.st = ST_OLD;
				end
			end
			ST_OLD: begin
				n.cnt = r.cnt + 2'h1;
				if (r.cnt == cks_pkg::OLD_PAUSE_CYC - 2'h1) begin
					n.cnt = 2'h0;
					n.st = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (sw.src_ready[r.tgt]) begin
					n.st = ST_NEW;
				end
			end
			ST_NEW: begin
				n.cnt = r.cnt + 2'h1;
				if (r.cnt == cks_pkg::NEW_PAUSE_CYC - 2'h1) begin
					n.cnt = 2'h0;
					n.active = r.tgt;
					n.hold = 1'b0;
					n.st = ST_RUN;
				end
			end
			default: begin
				n.st = ST_RUN;
				n.hold = 1'b0;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	// ==========================================================
	// Checks
	// pause length check.
	property p_pause_min;
		@(posedge core_clk) disable iff (!resetn)
		$rose(r.hold) |-> r.hold [*6];
	endproperty
	a_pause_min: assert property (p_pause_min)
		else $error("clock pause shorter than six cycles");

	property p_active_at_end;
		@(posedge core_clk) disable iff (!resetn)
		$changed(r.active) |-> $fell(r.hold);
	endproperty
	a_active_at_end: assert property (p_active_at_end)
		else $error("active source changed outside pause end");

	property p_switch_start;
		@(posedge core_clk) disable iff (!resetn)
		(r.st == ST_RUN && sw.req_src != r.active) |=> r.hold;
	endproperty
	a_switch_start: assert property (p_switch_start)
		else $error("switch did not start after new selection");

endmodule : cks_switch
`default_nettype wire

// ==== verification/cks_osc_model.sv ====
// Behavioural model of the primary, secondary and internal oscillators.
// Assumes the bench turns the primary and secondary on and off.
`timescale 1ns/1ps
`default_nettype none
module cks_osc_model #(
	parameter int PRI_NS = 53,
	parameter int SEC_NS = 2173
) (
	input wire logic pri_on,
	input wire logic sec_on,
	output logic internal_osc_ready,
	output logic primary_osc_ready,
	output logic secondary_osc_ready
);
	// ==========================================================
	// Oscillator start-up
	// internal starts unstable
	initial begin
		internal_osc_ready = 1'b0;
		#137;
		internal_osc_ready = 1'b1;
	end
	always begin
		primary_osc_ready = 1'b0;
		wait (pri_on === 1'b1);
		#(PRI_NS);
		primary_osc_ready = pri_on;
		wait (pri_on !== 1'b1);
	end
	always begin
		secondary_osc_ready = 1'b0;
		wait (sec_on === 1'b1);
		#(SEC_NS);
		secondary_osc_ready = sec_on;
		wait (sec_on !== 1'b1);
	end
endmodule : cks_osc_model
`default_nettype wire

// ==== verification/testbench.sv ====
// Self-checking bench for the clock source selector.
// Assumes the oscillator model and an AXI4-Lite master in this file.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
	mismatches++; $display("mismatch %s exp %h got %h", n, e, g); end end
module testbench;
	logic core_clk, resetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, dflt, cfg_loaded, sleep_exec;
	logic iready, pready, sready, clk_hold, sleep_enter, idle_enter;
	logic std, scr, pri_on, sec_on;
	logic [3:0] awaddr, araddr, wstrb;
	logic [31:0] wdata, rdata, rd_v;
	logic [1:0] bresp, rresp, clk_source, r;
	logic [2:0] pcfg, pmode;
	int mismatches = 0;
	int checks_done = 0;
	int n;

	cks_top #(.OST_CYCLES(8)) i_cks_top (.core_clk(core_clk),
		.resetn(resetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .primary_osc_config(pcfg),
		.default_source_select_cfg(dflt), .cfg_loaded(cfg_loaded),
		.internal_osc_ready(iready), .primary_osc_ready(pready),
		.secondary_osc_ready(sready), .sleep_exec(sleep_exec),
		.clk_source(clk_source), .clk_hold(clk_hold), .primary_mode(pmode),
		.sleep_enter(sleep_enter), .idle_enter(idle_enter),
		.startup_timer_done(std), .secondary_clock_running(scr));
	cks_osc_model i_cks_osc_model (.pri_on(pri_on), .sec_on(sec_on),
		.internal_osc_ready(iready), .primary_osc_ready(pready),
		.secondary_osc_ready(sready));

	// ==========================================================
	// Clock, expectations and bus tasks
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	function automatic logic [31:0] exp_osc(logic [1:0] s, logic d, logic i);
		return {24'h0, i, 3'h0, d, 1'b0, s};
	endfunction : exp_osc
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic ah, wh, bh;
		logic [1:0] br;
		@(posedge core_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge core_clk);
			ah = awready & awvalid;
			wh = wready & wvalid;
			bh = bvalid;
			br = bresp;
			@(posedge core_clk);
			if (ah) awvalid <= 1'b0;
			if (wh) wvalid <= 1'b0;
		end while (!bh);
		bready <= 1'b0;
		`CHK("bresp", 2'h0, br)
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [1:0] er);
		logic ah, rh;
		logic [1:0] rr;
		@(posedge core_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge core_clk);
			ah = arready;
			rh = rvalid;
			rr = rresp;
			rd_v = rdata;
			@(posedge core_clk);
			if (ah) arvalid <= 1'b0;
		end while (!rh);
		rready <= 1'b0;
		`CHK("rresp", er, rr)
	endtask : rd
	task automatic sw(input logic [1:0] e, input logic d, input logic s);
		logic [1:0] o;
		n = 0;
		while (!clk_hold) @(negedge core_clk);
		o = {std, scr};
		while (clk_hold) begin
			`CHK("status in hold", o, {std, scr})
			n++;
			@(negedge core_clk);
		end
		`CHK("hold length", 1'b1, n >= 6)
		`CHK("source", e, clk_source)
		@(negedge core_clk);
		`CHK("std", d, std)
		`CHK("scr", s, scr)
		`CHK("one status", 1'b0, std & scr)
	endtask : sw
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : complete_run

	// ==========================================================
	// Tests
	initial begin
		repeat (20000) @(posedge core_clk);
		mismatches++;
		complete_run();
	end
	initial begin
		void'($urandom(97));
		{resetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
		{cfg_loaded, sleep_exec, sec_on, awaddr, araddr, wdata} = 'h0;
		wstrb = 4'hf;
		pri_on = 1'b1;
		dflt = 1'b1;
		pcfg = 3'($urandom);
		repeat (16) @(posedge core_clk);
		resetn <= 1'b1;
		@(negedge core_clk);
		`CHK("boot source", 2'h0, clk_source)
		rd(4'h0, 2'h0);
		`CHK("osc reset", 32'h0, rd_v)
		rd(4'hc, 2'h2);
		`CHK("unmapped", 32'h0, rd_v)
		cfg_loaded <= 1'b1;
		sw(2'h1, 1'b1, 1'b0);
		`CHK("mode", pcfg, pmode)
		$display("test primary done");
		wr(4'h0, 32'h1);
		repeat (10) @(negedge core_clk);
		`CHK("ignored", 3'h1, {clk_hold, clk_source})
		sec_on <= 1'b1;
		wr(4'h4, {24'($urandom), 8'h08});
		sw(2'h2, 1'b0, 1'b1);
		rd(4'h4, 2'h0);
		`CHK("tmr reg", 32'h48, rd_v)
		$display("test secondary done");
		for (int i = 0; i < 2; i++) begin
			wr(4'h0, {24'($urandom), i[0], 5'h0, 2'h1});
			@(posedge core_clk);
			sleep_exec <= 1'b1;
			@(posedge core_clk);
			sleep_exec <= 1'b0;
			@(negedge core_clk);
			`CHK("sleep", {~i[0], i[0]}, {sleep_enter, idle_enter})
			rd(4'h0, 2'h0);
			`CHK("osc reg", exp_osc(2'h1, 1'b0, i[0]), rd_v)
		end
		$display("test sleep done");
		r = 2'h2 | 2'($urandom % 2);
		wr(4'h0, {30'h0, r});
		sw(2'h0, 1'b0, 1'b0);
		$display("test internal done");
		@(posedge core_clk);
		resetn <= 1'b0;
		cfg_loaded <= 1'b0;
		dflt <= 1'b0;
		repeat (16) @(posedge core_clk);
		resetn <= 1'b1;
		cfg_loaded <= 1'b1;
		repeat (20) @(negedge core_clk);
		`CHK("dflt internal", 3'h0, {clk_hold, clk_source})
		rd(4'h0, 2'h0);
		`CHK("osc rereset", exp_osc(2'h0, 1'b0, 1'b0), rd_v)
		$display("test reset done");
		complete_run();
	end
endmodule : testbench
`default_nettype wire
